/* File: adsc_reg_bank.sv */
// Top of the antenna driver segment control: AXI4-Lite register bank and driver stage.
module adsc_reg_bank (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite write address
	input  wire logic [adsc_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [adsc_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]                    s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [adsc_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	// AXI4-Lite read data
	output logic      [adsc_pkg::DATA_W-1:0]   s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// Commands and calibration engine
	input  wire logic                          set_default,
	input  wire logic                          cal_result_valid,
	input  wire logic [adsc_pkg::SEG_W-1:0]    cal_result,
	input  wire logic                          cal_level_valid,
	input  wire logic [adsc_pkg::LEVEL_W-1:0]  cal_level,
	// Transmitter state and driver outputs
	input  wire logic                          am_modulated,
	output logic                               modulated_level_source,
	output logic      [adsc_pkg::LEVEL_W-1:0]  target_level_bits,
	output logic      [adsc_pkg::SEG_W-1:0]    segment_on
);

	// ==========================================================================
	// Register storage
	// ==========================================================================
	logic [7:0] control_reg;
	logic [7:0] result_reg;
	logic [7:0] modmask_reg;
	logic [7:0] unmask_reg;

	// ==========================================================================
	// Write channel state
	// ==========================================================================
	typedef enum {ADSC_WR_COLLECT, ADSC_WR_RESP} adsc_wr_state_t;
	typedef enum {ADSC_RD_IDLE, ADSC_RD_RESP} adsc_rd_state_t;

	adsc_wr_state_t                 wr_state_reg;
	logic                           aw_held_reg;
	logic                           w_held_reg;
	logic [adsc_pkg::ADDR_W-1:0]    waddr_reg;
	logic [7:0]                     wdata_reg;
	logic                           wlane_reg;
	logic                           wr_commit;
	adsc_pkg::adsc_sel_t            wr_sel;

	// Address and data are taken independently, each while it is not yet held.
	assign s_axi_awready = (wr_state_reg == ADSC_WR_COLLECT) && !aw_held_reg;
	assign s_axi_wready  = (wr_state_reg == ADSC_WR_COLLECT) && !w_held_reg;
	assign wr_commit     = (wr_state_reg == ADSC_WR_COLLECT) && aw_held_reg
	                       && w_held_reg;
	assign wr_sel        = adsc_pkg::adsc_decode(waddr_reg);

	// Captures the write address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			waddr_reg   <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			waddr_reg   <= s_axi_awaddr;
		end else if (wr_commit) begin
			aw_held_reg <= 1'b0;
		end
	end

	// Captures the write data; only byte lane 0 carries register bits.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wlane_reg  <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata[7:0];
			wlane_reg  <= s_axi_wstrb[0];
		end else if (wr_commit) begin
			w_held_reg <= 1'b0;
		end
	end

	// Write response sequencing; a response is held until the master takes it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= ADSC_WR_COLLECT;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= adsc_pkg::RESP_OKAY;
		end else begin
			unique case (wr_state_reg)
				ADSC_WR_COLLECT: begin
					if (wr_commit) begin
						wr_state_reg <= ADSC_WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= (wr_sel == adsc_pkg::ADSC_SEL_NONE) ?
						                adsc_pkg::RESP_SLVERR :
						                adsc_pkg::RESP_OKAY;
					end
				end
				ADSC_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_reg <= ADSC_WR_COLLECT;
						s_axi_bvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Register updates
	// ==========================================================================
	logic sw_wr;

	assign sw_wr = wr_commit && wlane_reg;

	// Control register; a calibration update wins over a software write
	// in the same cycle, so a tuned level is never lost.
	always_ff @(posedge aclk) begin
		if (!aresetn || set_default) begin
			control_reg <= adsc_pkg::RST_CONTROL;
		end else begin
			if (sw_wr && wr_sel == adsc_pkg::ADSC_SEL_CONTROL) begin
				control_reg <= {wdata_reg[7:1], 1'b0};
			end
			if (cal_level_valid) begin
				control_reg[adsc_pkg::LEVEL_MSB:adsc_pkg::LEVEL_LSB] <=
					cal_level;
			end
		end
	end

	// Result register is filled only by calibration; bus writes never reach it.
	always_ff @(posedge aclk) begin
		if (!aresetn || set_default) begin
			result_reg <= adsc_pkg::RST_RESULT;
		end else if (cal_result_valid) begin
			result_reg <= cal_result;
		end
	end

	// Modulated and non-modulated segment masks.
	always_ff @(posedge aclk) begin
		if (!aresetn || set_default) begin
			modmask_reg <= adsc_pkg::RST_MODMASK;
			unmask_reg  <= adsc_pkg::RST_UNMASK;
		end else if (sw_wr) begin
			if (wr_sel == adsc_pkg::ADSC_SEL_MODMASK) begin
				modmask_reg <= wdata_reg;
			end
			if (wr_sel == adsc_pkg::ADSC_SEL_UNMASK) begin
				unmask_reg <= wdata_reg;
			end
		end
	end

	// ==========================================================================
	// Read channel
	// ==========================================================================
	adsc_rd_state_t      rd_state_reg;
	adsc_pkg::adsc_sel_t rd_sel;
	logic [7:0]          rd_byte;

	assign s_axi_arready = (rd_state_reg == ADSC_RD_IDLE);
	assign rd_sel        = adsc_pkg::adsc_decode(s_axi_araddr);

	// Read multiplexer; unmapped words read as zero with an error response.
	always_comb begin
		unique case (rd_sel)
			adsc_pkg::ADSC_SEL_CONTROL: rd_byte = control_reg;
			adsc_pkg::ADSC_SEL_RESULT:  rd_byte = result_reg;
			adsc_pkg::ADSC_SEL_MODMASK: rd_byte = modmask_reg;
			adsc_pkg::ADSC_SEL_UNMASK:  rd_byte = unmask_reg;
			default:                    rd_byte = 8'h00;
		endcase
	end

	// Read data is registered and held until the master takes it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_reg <= ADSC_RD_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= adsc_pkg::RESP_OKAY;
		end else begin
			unique case (rd_state_reg)
				ADSC_RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_state_reg <= ADSC_RD_RESP;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata  <= {24'h000000, rd_byte};
						s_axi_rresp  <= (rd_sel == adsc_pkg::ADSC_SEL_NONE) ?
						                adsc_pkg::RESP_SLVERR :
						                adsc_pkg::RESP_OKAY;
					end
				end
				ADSC_RD_RESP: begin
					if (s_axi_rready) begin
						rd_state_reg <= ADSC_RD_IDLE;
						s_axi_rvalid <= 1'b0;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Driver stage
	// ==========================================================================
	adsc_seg_if seg_cfg ();

	assign seg_cfg.source     = control_reg[adsc_pkg::SOURCE_BIT];
	assign seg_cfg.result     = result_reg;
	assign seg_cfg.mod_mask   = modmask_reg;
	assign seg_cfg.unmod_mask = unmask_reg;

	// Level and source go out straight from flip-flops for the analog side.
	assign modulated_level_source = control_reg[adsc_pkg::SOURCE_BIT];
	assign target_level_bits =
		control_reg[adsc_pkg::LEVEL_MSB:adsc_pkg::LEVEL_LSB];

	adsc_segment_drive u_drive (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.cfg          (seg_cfg),
		.am_modulated (am_modulated),
		.segment_on   (segment_on)
	);

	// ==========================================================================
	// Checks
	// ==========================================================================

	// Source 0 in the modulated state: enables are the inverted result.
	chk_src0_result: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(am_modulated && !control_reg[7]) |=> (segment_on == ~$past(result_reg))
	) else $error("modulated enables do not follow calibration result");

	// Source 1 in the modulated state: enables are the inverted direct mask.
	chk_src1_mask: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(am_modulated && control_reg[7]) |=> (segment_on == ~$past(modmask_reg))
	) else $error("modulated enables do not follow direct mask");

	// Plain transmission: enables are the inverted non-modulated mask.
	chk_unmod_mask: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!am_modulated |=> (segment_on == ~$past(unmask_reg))
	) else $error("plain enables do not follow non-modulated mask");

	// A segment bit follows only its own mask bit.
	chk_seg_weight: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(!am_modulated && unmask_reg == 8'h80) |=> (segment_on == 8'h7F)
	) else $error("heaviest segment mapped to wrong bit");

	// Calibration result appears in the result register one edge later.
	chk_result_load: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(cal_result_valid && !set_default) |=> (result_reg == $past(cal_result))
	) else $error("calibration result not stored");

	// Set-default clears every register at the next edge.
	chk_set_default: assert property (
		@(posedge aclk) disable iff (!aresetn)
		set_default |=> (control_reg == 8'h00 && result_reg == 8'h00
		                 && modmask_reg == 8'h00 && unmask_reg == 8'h00)
	) else $error("set-default left a register nonzero");

	// The unused control bit never becomes one.
	chk_unused_bit: assert property (
		@(posedge aclk) disable iff (!aresetn)
		control_reg[0] == 1'b0
	) else $error("unused control bit set");

	// A software write to the control register lands in its fields.
	chk_ctrl_write: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(sw_wr && wr_sel == adsc_pkg::ADSC_SEL_CONTROL && !set_default
		 && !cal_level_valid) |=> (control_reg == {$past(wdata_reg[7:1]), 1'b0})
	) else $error("control write not stored");

	// Without calibration activity the result register holds its value.
	chk_result_ro: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(!cal_result_valid && !set_default) |=> $stable(result_reg)
	) else $error("result register changed without calibration");

	// A response appears one edge after both halves of a write are held.
	chk_write_resp: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_commit |=> s_axi_bvalid
	) else $error("write response missing");

	// The response and its code stand until the master takes them.
	chk_write_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=>
			(s_axi_bvalid && $stable(s_axi_bresp))
	) else $error("write response dropped before it was taken");

	// A calibration level wins over a same-cycle software write.
	chk_cal_level: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(cal_level_valid && !set_default) |=>
			(target_level_bits == $past(cal_level))
	) else $error("calibration level not stored");

	// Read data stays stable while the master stalls.
	chk_read_hold: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata))
	) else $error("read data dropped before it was taken");

	// A read is answered at the edge after the address is taken.
	chk_read_lat: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid
	) else $error("read response late");

endmodule

/* File: adsc_pkg.sv */
// Package with register map, field layout and reset values of the driver segment control.
package adsc_pkg;

	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned SEG_W   = 8;
	localparam int unsigned LEVEL_W = 6;

	// ==========================================================================
	// Register indices; the byte address is four times the index
	// ==========================================================================
	localparam logic [5:0] IDX_CONTROL = 6'h10;
	localparam logic [5:0] IDX_RESULT  = 6'h11;
	localparam logic [5:0] IDX_MODMASK = 6'h12;
	localparam logic [5:0] IDX_UNMASK  = 6'h13;

	// ==========================================================================
	// Field positions inside the control register
	// ==========================================================================
	localparam int unsigned SOURCE_BIT = 7;
	localparam int unsigned LEVEL_MSB  = 6;
	localparam int unsigned LEVEL_LSB  = 1;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [7:0]       RST_CONTROL = 8'h00;
	localparam logic [7:0]       RST_RESULT  = 8'h00;
	localparam logic [7:0]       RST_MODMASK = 8'h00;
	localparam logic [7:0]       RST_UNMASK  = 8'h00;
	localparam logic [SEG_W-1:0] SEG_ALL_ON  = 8'hFF;

	// ==========================================================================
	// Bus responses
	// ==========================================================================
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================================
	// Register selection
	// ==========================================================================
	typedef enum logic [2:0] {
		ADSC_SEL_CONTROL,
		ADSC_SEL_RESULT,
		ADSC_SEL_MODMASK,
		ADSC_SEL_UNMASK,
		ADSC_SEL_NONE
	} adsc_sel_t;

	// Maps a byte address to a register; the two low address bits are ignored.
	function automatic adsc_sel_t adsc_decode(input logic [ADDR_W-1:0] addr);
		adsc_sel_t sel;
		unique case (addr[ADDR_W-1:2])
			IDX_CONTROL: sel = ADSC_SEL_CONTROL;
			IDX_RESULT:  sel = ADSC_SEL_RESULT;
			IDX_MODMASK: sel = ADSC_SEL_MODMASK;
			IDX_UNMASK:  sel = ADSC_SEL_UNMASK;
			default:     sel = ADSC_SEL_NONE;
		endcase
		return sel;
	endfunction

endpackage

/* File: adsc_seg_if.sv */
// Interface carrying segment configuration from the register bank to the driver stage.
interface adsc_seg_if;
	logic                       source;
	logic [adsc_pkg::SEG_W-1:0] result;
	logic [adsc_pkg::SEG_W-1:0] mod_mask;
	logic [adsc_pkg::SEG_W-1:0] unmod_mask;

	modport cfg (output source, output result, output mod_mask, output unmod_mask);
	modport drv (input source, input result, input mod_mask, input unmod_mask);
endinterface

/* File: adsc_segment_drive.sv */
// Driver stage turning the segment masks or the calibration result into per-segment enables.
module adsc_segment_drive (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// Configuration
	adsc_seg_if.drv                         cfg,
	// Transmit state
	input  wire logic                       am_modulated,
	// Segment enables, one bit per binary-weighted segment
	output logic      [adsc_pkg::SEG_W-1:0] segment_on
);

	// ==========================================================================
	// Per-segment selection
	// ==========================================================================
	logic [adsc_pkg::SEG_W-1:0] seg_off;

	// Each segment has its own switch; bit 7 is the heaviest weight.
	genvar i;
	generate
		for (i = 0; i < adsc_pkg::SEG_W; i++) begin : g_seg
			always_comb begin
				if (am_modulated) begin
					// Direct mask or calibration result, by source.
					seg_off[i] = cfg.source ? cfg.mod_mask[i] : cfg.result[i];
				end else begin
					seg_off[i] = cfg.unmod_mask[i];
				end
			end
		end
	endgenerate

	// Registered so that the analog switches never see a decode glitch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			segment_on <= adsc_pkg::SEG_ALL_ON;
		end else begin
			segment_on <= ~seg_off;
		end
	end

endmodule

/* File: adsc_reg_bank_test.sv */
// Self-checking testbench for the antenna driver segment control register bank.
module adsc_reg_bank_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// Addresses, signals and counters
	// ==========================================================================
	localparam logic [7:0] A_CTL = {adsc_pkg::IDX_CONTROL, 2'b00};
	localparam logic [7:0] A_RES = {adsc_pkg::IDX_RESULT, 2'b00};
	localparam logic [7:0] A_MOD = {adsc_pkg::IDX_MODMASK, 2'b00};
	localparam logic [7:0] A_UNM = {adsc_pkg::IDX_UNMASK, 2'b00};
	localparam logic [7:0] A_BAD = 8'h50;

	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        set_default;
	logic        cal_result_valid;
	logic [7:0]  cal_result;
	logic        cal_level_valid;
	logic [5:0]  cal_level;
	logic        am_modulated;
	logic        src;
	logic [5:0]  level;
	logic [7:0]  segment_on;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          error_cnt;
	int          checks_done;

	// ==========================================================================
	// Device under test
	// ==========================================================================
	adsc_reg_bank uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .set_default(set_default),
		.cal_result_valid(cal_result_valid), .cal_result(cal_result),
		.cal_level_valid(cal_level_valid), .cal_level(cal_level),
		.am_modulated(am_modulated), .modulated_level_source(src),
		.target_level_bits(level), .segment_on(segment_on)
	);

	// Free-running 200 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ==========================================================================
	// Shared tasks
	// ==========================================================================
	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Four-state compare, so an unknown never counts as a match.
	task automatic check(input string name, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask

	// A bus wait that ran out of cycles ends the run.
	task automatic timeout_hit(input logic ok);
		if (!ok) begin
			error_cnt++;
			$display("ERROR bus_answer expected 1 seen 0");
			finish_test();
		end
	endtask

	// Readies are sampled at the falling edge, where they have settled.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] resp);
		logic aw_ok, w_ok, aw_hit, w_hit, b_ok;
		int   n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		resp = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
			@(negedge aclk);
			aw_hit = !aw_ok && awready === 1'b1;
			w_hit = !w_ok && wready === 1'b1;
			@(posedge aclk);
			if (aw_hit) begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (w_hit) begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		timeout_hit(aw_ok && w_ok);
		bready <= 1'b1;
		for (n = 0; n < 100 && !b_ok; n++) begin
			@(negedge aclk);
			b_ok = bvalid === 1'b1;
			resp = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		timeout_hit(b_ok);
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		logic a_ok, r_ok;
		int   n;
		a_ok = 1'b0;
		r_ok = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 100 && !a_ok; n++) begin
			@(negedge aclk);
			a_ok = arready === 1'b1;
			@(posedge aclk);
		end
		timeout_hit(a_ok);
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (n = 0; n < 100 && !r_ok; n++) begin
			@(negedge aclk);
			r_ok = rvalid === 1'b1;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		timeout_hit(r_ok);
	endtask

	// Segment outputs follow their inputs one edge later.
	task automatic seg_check(input logic [7:0] e);
		@(posedge aclk);
		@(negedge aclk);
		check("segment_on", {24'h0, e}, {24'h0, segment_on});
	endtask

	// Reads one register and compares data and response.
	task automatic read_check(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		axi_read(a, rd, rs);
		check("rdata", e, rd);
		check("rresp", {30'h0, er}, {30'h0, rs});
	endtask

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic test_reset;
		read_check(A_CTL, 32'h0, adsc_pkg::RESP_OKAY);
		read_check(A_RES, 32'h0, adsc_pkg::RESP_OKAY);
		read_check(A_MOD, 32'h0, adsc_pkg::RESP_OKAY);
		read_check(A_UNM, 32'h0, adsc_pkg::RESP_OKAY);
		seg_check(8'hFF);
		$display("test_reset done");
	endtask

	// Bit 0 of the control register is never stored.
	task automatic test_control;
		axi_write(A_CTL, 32'hFF, rs);
		read_check(A_CTL, 32'hFE, adsc_pkg::RESP_OKAY);
		check("source", 32'h1, {31'h0, src});
		check("level", 32'h3F, {26'h0, level});
		@(posedge aclk);
		cal_level <= 6'h2A;
		cal_level_valid <= 1'b1;
		@(posedge aclk);
		cal_level_valid <= 1'b0;
		read_check(A_CTL, 32'hD4, adsc_pkg::RESP_OKAY);
		check("level", 32'h2A, {26'h0, level});
		$display("test_control done");
	endtask

	// A software write must not disturb the calibration result.
	task automatic test_result;
		@(posedge aclk);
		cal_result <= 8'hA5;
		cal_result_valid <= 1'b1;
		@(posedge aclk);
		cal_result_valid <= 1'b0;
		read_check(A_RES, 32'hA5, adsc_pkg::RESP_OKAY);
		axi_write(A_RES, 32'h00, rs);
		check("bresp", 32'h0, {30'h0, rs});
		read_check(A_RES, 32'hA5, adsc_pkg::RESP_OKAY);
		$display("test_result done");
	endtask

	// Distinct result and mask values expose swapped sources; one-hot non-modulated masks expose a reversed order.
	task automatic test_segments;
		axi_write(A_CTL, 32'h00, rs);
		@(posedge aclk);
		am_modulated <= 1'b1;
		seg_check(8'h5A);
		axi_write(A_MOD, 32'h3C, rs);
		read_check(A_MOD, 32'h3C, adsc_pkg::RESP_OKAY);
		seg_check(8'h5A);
		axi_write(A_CTL, 32'h80, rs);
		seg_check(8'hC3);
		@(posedge aclk);
		am_modulated <= 1'b0;
		axi_write(A_UNM, 32'h01, rs);
		seg_check(8'hFE);
		axi_write(A_UNM, 32'h80, rs);
		read_check(A_UNM, 32'h80, adsc_pkg::RESP_OKAY);
		seg_check(8'h7F);
		$display("test_segments done");
	endtask

	task automatic test_unmapped;
		axi_write(A_BAD, 32'h5A, rs);
		check("bresp", 32'h2, {30'h0, rs});
		read_check(A_BAD, 32'h0, adsc_pkg::RESP_SLVERR);
		// A write without byte lane 0 is answered but leaves the mask alone.
		@(posedge aclk);
		wstrb <= 4'hE;
		axi_write(A_UNM, 32'h33, rs);
		wstrb <= 4'hF;
		check("bresp", 32'h0, {30'h0, rs});
		read_check(A_UNM, 32'h80, adsc_pkg::RESP_OKAY);
		$display("test_unmapped done");
	endtask

	// The command clears every register while the link is modulating.
	task automatic test_defaults;
		@(posedge aclk);
		am_modulated <= 1'b1;
		set_default <= 1'b1;
		@(posedge aclk);
		set_default <= 1'b0;
		read_check(A_CTL, 32'h0, adsc_pkg::RESP_OKAY);
		read_check(A_RES, 32'h0, adsc_pkg::RESP_OKAY);
		read_check(A_MOD, 32'h0, adsc_pkg::RESP_OKAY);
		read_check(A_UNM, 32'h0, adsc_pkg::RESP_OKAY);
		seg_check(8'hFF);
		$display("test_defaults done");
	endtask

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{set_default, cal_result_valid, cal_level_valid, am_modulated} = 4'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		cal_result = 8'h00;
		cal_level = 6'h00;
		error_cnt = 0;
		checks_done = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		test_reset();
		test_control();
		test_result();
		test_segments();
		test_unmapped();
		test_defaults();
		finish_test();
	end
endmodule
